// ### flash_host_write_and_mux_port.sv
// Link write cycle and multiplexed programming port of a byte-wide flash
`timescale 1ns/1ps
// Functional notes
// - Address bit 22 picks array or registers
// - Device takes the lines in cycle 14
// - Device drives sync zero in cycle 15
// - Drive ones in 16, float in 17
// - Multiplexed mode leaves every block unprotected
// - Multiplexed mode hides security and registers
// - Read drives byte when enable low
// - Read source follows the read mode
// - Write byte captured at strobe rising edge
// - Output enable high floats data pins
// - Reset pin low floats outputs, clears state
// - Reset during program or erase aborts it
// - Signature codes chosen by address bit 0
// - Frame low mid-cycle aborts and floats lines
// - Command issued once data byte received
module flash_host_write_and_mux_port
  import flash_port_pkg::*;
#(
  parameter int ADDR_W = LPC_ADDR_W,
  parameter int MAW = MUX_ADDR_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Device pins
  input wire logic interface_reset_n,
  input wire logic mux_mode_pin,
  // Low pin count link
  input wire logic lframe_n,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe_n,
  // Multiplexed programming port
  input wire logic [MAW-1:0] muxed_addr_in,
  input wire logic row_col_select,
  input wire logic out_enable_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_io_in,
  output logic [7:0] data_io_out,
  output logic data_io_oe_n,
  // Command interpreter side
  input wire read_mode_type read_mode,
  input wire logic [7:0] array_rdata,
  input wire logic [7:0] status_rdata,
  input wire logic pe_busy,
  output logic [2*MAW-1:0] mux_rd_addr,
  output logic cmd_valid,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [7:0] cmd_data,
  output logic cmd_to_array,
  output logic pe_abort,
  output logic block_unprotect,
  output logic regs_enable
);

  // ==========================================
  // Reset and interface selection

  logic int_rst; // Clock reset or reset pin low
  logic lpc_rst; // Link logic held while the other port is active
  logic mux_mode_reg; // Interface choice caught during reset
  logic rp_prev_reg; // Reset pin level last cycle
  logic pe_abort_reg; // Abort request to the program/erase controller
  logic unprot_reg; // All blocks unprotected
  logic regs_en_reg; // Register space reachable

  // Reset pin holds both ports and the command hand-off in reset
  assign int_rst = sys_rst || !interface_reset_n;
  assign lpc_rst = int_rst || mux_mode_reg;

  // Interface strap sampled only while held in reset
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      mux_mode_reg <= mux_mode_pin;
    end
  end

  // Protection and register visibility follow the interface
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      unprot_reg <= 1'b0;
      regs_en_reg <= 1'b1;
    end else begin
      unprot_reg <= mux_mode_reg;
      regs_en_reg <= !mux_mode_reg;
    end
  end

  // Falling reset pin while busy kills the running operation
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rp_prev_reg <= 1'b1;
      pe_abort_reg <= 1'b0;
    end else begin
      rp_prev_reg <= interface_reset_n;
      pe_abort_reg <= rp_prev_reg && !interface_reset_n && pe_busy;
    end
  end

  // ==========================================
  // Link write state machine

  lpc_state_type state_reg; // Current field
  lpc_state_type state_next;
  logic [2:0] cnt_reg; // Nibble counter inside a field
  logic [2:0] cnt_next;
  logic [ADDR_W-1:0] addr_reg; // Address shifted in high nibble first
  logic [ADDR_W-1:0] addr_next;
  logic [3:0] low_nib_reg; // Low data nibble
  logic [3:0] low_nib_next;
  logic [3:0] lad_reg; // Nibble driven on the link
  logic [3:0] lad_next;
  logic lad_oe_n_reg; // Link drive enable, low while driving
  logic lad_oe_n_next;
  logic lpc_cmd; // Data byte complete this edge
  logic start_seen; // Frame low with start nibble
  logic type_ok; // Cycle type marks a write
  logic frame_abort; // Frame low inside a transaction

  // Field decode on the sampled nibble
  assign start_seen = !lframe_n && (lad_in == START_CODE);
  assign type_ok = (lad_in[3:1] == WRITE_TYPE);
  assign frame_abort = (state_reg != ST_IDLE) && !lframe_n;

  // Next state, counters and link drive
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    low_nib_next = low_nib_reg;
    lad_next = TAR_CODE;
    lad_oe_n_next = 1'b1;
    lpc_cmd = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // Wait for a start
        if (start_seen) begin
          state_next = ST_CYCTYPE;
        end
      end
      ST_CYCTYPE: begin
        // Only a write type goes on; others are dropped
        if (type_ok) begin
          state_next = ST_ADDR;
          cnt_next = 3'h0;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_ADDR: begin
        // Shift in eight nibbles, most significant first
        addr_next = {addr_reg[ADDR_W-5:0], lad_in};
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == ADDR_LAST) begin
          state_next = ST_DATA;
          cnt_next = 3'h0;
        end
      end
      ST_DATA: begin
        // Low nibble first, byte done on the second
        if (cnt_reg == 3'h0) begin
          low_nib_next = lad_in;
          cnt_next = 3'h1;
        end else begin
          lpc_cmd = 1'b1;
          state_next = ST_TAR_HOST;
        end
      end
      ST_TAR_HOST: begin
        // Host turnaround seen; take the lines next cycle
        state_next = ST_TAR_DEV;
        lad_oe_n_next = 1'b0;
        lad_next = TAR_CODE;
      end
      ST_TAR_DEV: begin
        // Acknowledge with no wait states
        state_next = ST_SYNC;
        lad_oe_n_next = 1'b0;
        lad_next = SYNC_OK;
      end
      ST_SYNC: begin
        // Drive ones before handing back
        state_next = ST_TAR_END;
        lad_oe_n_next = 1'b0;
        lad_next = TAR_CODE;
      end
      ST_TAR_END: begin
        // Float the lines
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // A frame strobe inside a cycle wins; a fresh start restarts it
    if (frame_abort) begin
      state_next = start_seen ? ST_CYCTYPE : ST_IDLE;
      lad_oe_n_next = 1'b1;
      lad_next = TAR_CODE;
      lpc_cmd = 1'b0;
    end
  end

  // Link registers
  always_ff @(posedge sys_clk) begin
    if (lpc_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      addr_reg <= ADDR_ZERO;
      low_nib_reg <= TAR_CODE;
      lad_reg <= TAR_CODE;
      lad_oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      low_nib_reg <= low_nib_next;
      lad_reg <= lad_next;
      lad_oe_n_reg <= lad_oe_n_next;
    end
  end

  assign lad_out = lad_reg;
  assign lad_oe_n = lad_oe_n_reg;

  // ==========================================
  // Multiplexed programming port

  logic mux_rst; // Port held while the link is active
  logic [2*MAW-1:0] mux_addr; // Latched row and column
  logic mux_wr; // Write strobe completed
  logic [7:0] mux_wr_data; // Byte from the programmer

  assign mux_rst = int_rst || !mux_mode_reg;

  // Address latch
  mux_addr_latch #(
    .AW(MAW)
  ) u_addr (
    .sys_clk(sys_clk),
    .rst(mux_rst),
    .muxed_addr_in(muxed_addr_in),
    .row_col_select(row_col_select),
    .addr(mux_addr)
  );

  // Data pins and write capture
  mux_data_port #(
    .AW(2 * MAW)
  ) u_data (
    .sys_clk(sys_clk),
    .rst(mux_rst),
    .enable(mux_mode_reg),
    .out_enable_n(out_enable_n),
    .write_strobe_n(write_strobe_n),
    .data_in(data_io_in),
    .addr(mux_addr),
    .read_mode(read_mode),
    .array_rdata(array_rdata),
    .status_rdata(status_rdata),
    .data_out(data_io_out),
    .data_oe_n(data_io_oe_n),
    .wr_pulse(mux_wr),
    .wr_data(mux_wr_data)
  );

  // ==========================================
  // Command hand-off to the interpreter

  logic cmd_valid_reg; // One cycle command strobe
  logic [ADDR_W-1:0] cmd_addr_reg; // Target address
  logic [7:0] cmd_data_reg; // Command or data byte
  logic cmd_array_reg; // Array target when high
  logic [2*MAW-1:0] rd_addr_reg; // Read address to the array
  logic [ADDR_W-1:0] mux_addr_wide; // Port address padded to link width

  assign mux_addr_wide = {{(ADDR_W - 2 * MAW){1'b0}}, mux_addr};

  // Source picked by the active interface
  always_ff @(posedge sys_clk) begin
    if (int_rst) begin
      cmd_valid_reg <= 1'b0;
      cmd_addr_reg <= ADDR_ZERO;
      cmd_data_reg <= BYTE_ZERO;
      cmd_array_reg <= 1'b0;
      rd_addr_reg <= '0;
    end else begin
      rd_addr_reg <= mux_addr;
      if (mux_mode_reg) begin
        cmd_valid_reg <= mux_wr;
        cmd_addr_reg <= mux_addr_wide;
        cmd_data_reg <= mux_wr_data;
        cmd_array_reg <= 1'b1;
      end else begin
        cmd_valid_reg <= lpc_cmd;
        cmd_addr_reg <= addr_reg;
        cmd_data_reg <= {lad_in, low_nib_reg};
        cmd_array_reg <= addr_reg[ARRAY_SEL_BIT];
      end
    end
  end

  assign cmd_valid = cmd_valid_reg;
  assign cmd_addr = cmd_addr_reg;
  assign cmd_data = cmd_data_reg;
  assign cmd_to_array = cmd_array_reg;
  assign mux_rd_addr = rd_addr_reg;
  assign pe_abort = pe_abort_reg;
  assign block_unprotect = unprot_reg;
  assign regs_enable = regs_en_reg;

  // ==========================================
  // Checks

  property p_take_lines;
    @(posedge sys_clk) disable iff (lpc_rst)
      (state_reg == ST_TAR_HOST && lframe_n) |=> (!lad_oe_n && lad_out == TAR_CODE);
  endproperty
  a_take_lines: assert property (p_take_lines) else $error("lines not taken");

  property p_sync;
    @(posedge sys_clk) disable iff (lpc_rst)
      (state_reg == ST_TAR_DEV && lframe_n) |=> (!lad_oe_n && lad_out == SYNC_OK);
  endproperty
  a_sync: assert property (p_sync) else $error("sync not driven");

  property p_hand_back;
    @(posedge sys_clk) disable iff (lpc_rst)
      (state_reg == ST_SYNC && lframe_n ##1 lframe_n)
        |-> (!lad_oe_n && lad_out == TAR_CODE) ##1 lad_oe_n;
  endproperty
  a_hand_back: assert property (p_hand_back) else $error("bus not handed back");

  property p_abort;
    @(posedge sys_clk) disable iff (lpc_rst)
      frame_abort |=> lad_oe_n;
  endproperty
  a_abort: assert property (p_abort) else $error("lines driven after abort");

  property p_bad_type;
    @(posedge sys_clk) disable iff (lpc_rst)
      (state_reg == ST_CYCTYPE && lframe_n && !type_ok) |=> (state_reg == ST_IDLE);
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("bad cycle type taken");

  property p_cmd_issue;
    @(posedge sys_clk) disable iff (int_rst)
      (!mux_mode_reg && state_reg == ST_DATA && cnt_reg == 3'h1 && lframe_n)
        |=> (cmd_valid && cmd_to_array == $past(addr_reg[ARRAY_SEL_BIT]));
  endproperty
  a_cmd_issue: assert property (p_cmd_issue) else $error("command not issued");

  property p_reset_pin;
    @(posedge sys_clk) disable iff (sys_rst)
      !interface_reset_n |=> (lad_oe_n && data_io_oe_n && !cmd_valid);
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("outputs live in reset");

  property p_pe_abort;
    @(posedge sys_clk) disable iff (sys_rst)
      (interface_reset_n ##1 !interface_reset_n && pe_busy) |=> pe_abort;
  endproperty
  a_pe_abort: assert property (p_pe_abort) else $error("operation not aborted");

  property p_unprot;
    @(posedge sys_clk) disable iff (sys_rst)
      !sys_rst |=> (block_unprotect == $past(mux_mode_reg) &&
        regs_enable == !$past(mux_mode_reg));
  endproperty
  a_unprot: assert property (p_unprot) else $error("protection not released");

endmodule

// ### flash_port_pkg.sv
// Shared constants and types for the flash host write and multiplexed port
package flash_port_pkg;

  // ==========================================
  // Low pin count field codes
  localparam logic [3:0] START_CODE = 4'h0; // Start nibble
  localparam logic [2:0] WRITE_TYPE = 3'h3; // Cycle type bits 3:1 for a write
  localparam logic [3:0] TAR_CODE = 4'hF; // Turnaround level
  localparam logic [3:0] SYNC_OK = 4'h0; // Sync: data accepted, no wait

  // ==========================================
  // Field sizes and positions
  localparam int LPC_ADDR_W = 32; // Address bits sent on the link
  localparam logic [2:0] ADDR_LAST = 3'h7; // Index of the eighth address nibble
  localparam int ARRAY_SEL_BIT = 22; // Address bit choosing array or registers
  localparam int MUX_ADDR_W = 11; // Multiplexed address inputs
  localparam int SIG_HI = 18; // Top of signature address field
  localparam int SIG_LO = 1; // Bottom of signature address field

  // ==========================================
  // Reset values and fill bytes
  localparam logic [7:0] BYTE_ZERO = 8'h00; // Cleared data byte
  localparam logic [31:0] ADDR_ZERO = 32'h0000_0000; // Cleared address

  // ==========================================
  // Link state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CYCTYPE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_TAR_HOST = 3'b100,
    ST_TAR_DEV = 3'b101,
    ST_SYNC = 3'b110,
    ST_TAR_END = 3'b111
  } lpc_state_type;

  // ==========================================
  // Read source chosen by the command interpreter
  typedef enum logic [1:0] {
    RD_ARRAY = 2'b00,
    RD_SIGNATURE = 2'b01,
    RD_STATUS = 2'b10
  } read_mode_type;

endpackage

// ### lpc_host_model.sv
// Link host model that runs write cycles and records the device answer
`timescale 1ns/1ps
module lpc_host_model (
  // Clock
  input wire logic sys_clk,
  // Device drive
  input wire logic [3:0] lad_out,
  input wire logic lad_oe_n,
  // Host drive
  output logic lframe_n,
  output logic [3:0] lad_in
);
  logic host_en = 1'b0; // Host owns the lines
  logic [3:0] host_val = 4'hF; // Host nibble
  logic [3:0] seen [1:17]; // Line level per cycle
  logic oe_seen [1:17]; // Device enable per cycle
  initial lframe_n = 1'b1;
  // Released lines rest high through the pull-ups
  assign lad_in = !lad_oe_n ? lad_out : (host_en ? host_val : 4'hF);
  // ====
  // One write cycle, cut short by a frame strobe in cycle abort_at
  task automatic write_cycle(input logic [31:0] a, input logic [7:0] d,
                             input logic [3:0] ct, input int abort_at);
    for (int c = 1; c <= 17; c++) begin
      @(posedge sys_clk);
      // Abort drives frame low with a non-start nibble, then the host lets go
      host_en <= (c == abort_at) || (c <= 13 && (abort_at == 0 || c < abort_at));
      lframe_n <= (c != 1) && (c != abort_at);
      if (c == 1) host_val <= 4'h0;
      else if (c == abort_at) host_val <= 4'hF;
      else if (c == 2) host_val <= ct;
      else if (c <= 10) host_val <= a[4*(10-c) +: 4];
      else if (c <= 12) host_val <= d[4*(c-11) +: 4];
      else host_val <= 4'hF;
      #1;
      seen[c] = lad_in;
      oe_seen[c] = lad_oe_n;
    end
  endtask
endmodule

// ### mux_addr_latch.sv
// Row and column address latch of the multiplexed programming port
`timescale 1ns/1ps
module mux_addr_latch
  import flash_port_pkg::*;
#(
  parameter int AW = MUX_ADDR_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Programmer pins
  input wire logic [AW-1:0] muxed_addr_in,
  input wire logic row_col_select,
  // Assembled address
  output logic [2*AW-1:0] addr
);

  logic rc_prev_reg; // Select level seen last cycle
  logic [2*AW-1:0] addr_reg; // Row half low, column half high
  logic row_take; // Falling select edge
  logic col_take; // Rising select edge

  // Edge decode of the row/column select
  assign row_take = rc_prev_reg && !row_col_select;
  assign col_take = !rc_prev_reg && row_col_select;
  assign addr = addr_reg;

  // ==========================================
  // Row half then column half
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rc_prev_reg <= 1'b1;
      addr_reg <= '0;
    end else begin
      rc_prev_reg <= row_col_select;
      if (row_take) begin
        addr_reg[AW-1:0] <= muxed_addr_in;
      end else if (col_take) begin
        addr_reg[2*AW-1:AW] <= muxed_addr_in;
      end
    end
  end

  property p_row_latch;
    @(posedge sys_clk) disable iff (rst)
      (rc_prev_reg && !row_col_select) |=> (addr[AW-1:0] == $past(muxed_addr_in));
  endproperty
  a_row_latch: assert property (p_row_latch) else $error("row half not latched");

endmodule

// ### mux_data_port.sv
// Data pins, read selection and write capture of the multiplexed port
`timescale 1ns/1ps
module mux_data_port
  import flash_port_pkg::*;
#(
  parameter int AW = 2 * MUX_ADDR_W,
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'hA5 // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  // Programmer controls
  input wire logic out_enable_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_in,
  input wire logic [AW-1:0] addr,
  // Read sources
  input wire read_mode_type read_mode,
  input wire logic [7:0] array_rdata,
  input wire logic [7:0] status_rdata,
  // Pin drive
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Captured write
  output logic wr_pulse,
  output logic [7:0] wr_data
);

  logic ws_prev_reg; // Write strobe seen last cycle
  logic [7:0] out_reg; // Byte on the data pins
  logic oe_n_reg; // Pin enable, low while driving
  logic wr_reg; // One cycle write pulse
  logic [7:0] wr_data_reg; // Captured byte
  logic read_on; // Read conditions met
  logic ws_rise; // End of write strobe
  logic sig_zero; // Signature address field all low
  logic [7:0] sig_byte; // Maker or part code
  logic [7:0] rd_byte; // Selected read byte

  // Read cycle: output enable low with write strobe high
  assign read_on = enable && !out_enable_n && write_strobe_n;
  assign ws_rise = enable && out_enable_n && !ws_prev_reg && write_strobe_n;
  // Signature codes by the low address bit
  assign sig_zero = (addr[SIG_HI:SIG_LO] == '0);
  assign sig_byte = !sig_zero ? BYTE_ZERO : (addr[0] ? PART_ID : MAKER_ID);
  // Source chosen by the current read mode
  assign rd_byte = (read_mode == RD_STATUS) ? status_rdata :
                   (read_mode == RD_SIGNATURE) ? sig_byte : array_rdata;
  assign data_out = out_reg;
  assign data_oe_n = oe_n_reg;
  assign wr_pulse = wr_reg;
  assign wr_data = wr_data_reg;

  // ==========================================
  // Pin drive and write capture
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ws_prev_reg <= 1'b1;
      out_reg <= BYTE_ZERO;
      oe_n_reg <= 1'b1;
      wr_reg <= 1'b0;
      wr_data_reg <= BYTE_ZERO;
    end else begin
      ws_prev_reg <= write_strobe_n;
      out_reg <= rd_byte;
      oe_n_reg <= !read_on;
      wr_reg <= ws_rise;
      if (!write_strobe_n) begin
        wr_data_reg <= data_in;
      end
    end
  end

  property p_oe_hiz;
    @(posedge sys_clk) disable iff (rst)
      out_enable_n |=> data_oe_n;
  endproperty
  a_oe_hiz: assert property (p_oe_hiz) else $error("data pins driven with enable high");

  property p_write_capture;
    @(posedge sys_clk) disable iff (rst)
      (enable && out_enable_n && !write_strobe_n ##1 write_strobe_n && out_enable_n)
        |=> (wr_pulse && wr_data == $past(data_in, 2));
  endproperty
  a_write_capture: assert property (p_write_capture) else $error("write byte lost");

  property p_read_drive;
    @(posedge sys_clk) disable iff (rst)
      (read_on && !rst) |=> (!data_oe_n && data_out == $past(rd_byte));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read byte not driven");

endmodule

// ### tb_top.sv
// Self-checking bench for the link write and multiplexed port
`timescale 1ns/1ps
module tb_top;
  import flash_port_pkg::*;
  localparam logic [7:0] EXP_MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] EXP_PART = 8'hA5; // Arbitrary value
  // ====
  // Stimulus and observed signals
  logic sys_clk = 1'b0, sys_rst = 1'b1, interface_reset_n = 1'b1, mux_mode_pin = 1'b0;
  logic lframe_n, lad_oe_n, row_col_select = 1'b1, out_enable_n = 1'b1;
  logic write_strobe_n = 1'b1, data_io_oe_n, pe_busy = 1'b0, pe_abort, cmd_valid;
  logic [3:0] lad_in, lad_out;
  logic [10:0] muxed_addr_in = 11'h000;
  logic [7:0] data_io_in = 8'h00, data_io_out, cmd_data, got_data;
  logic [7:0] array_rdata = 8'h3C, status_rdata = 8'h80;
  read_mode_type read_mode = RD_ARRAY;
  logic [21:0] mux_rd_addr;
  logic [31:0] cmd_addr, got_addr;
  logic cmd_to_array, got_arr, block_unprotect, regs_enable;
  int miscompares = 0, n_tests = 0, n_cmd = 0, n_abort = 0;
  always #12.5 sys_clk = ~sys_clk;
  flash_host_write_and_mux_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .interface_reset_n(interface_reset_n), .mux_mode_pin(mux_mode_pin),
    .lframe_n(lframe_n), .lad_in(lad_in), .lad_out(lad_out), .lad_oe_n(lad_oe_n),
    .muxed_addr_in(muxed_addr_in), .row_col_select(row_col_select),
    .out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n),
    .data_io_in(data_io_in), .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n),
    .read_mode(read_mode), .array_rdata(array_rdata), .status_rdata(status_rdata),
    .pe_busy(pe_busy), .mux_rd_addr(mux_rd_addr), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_to_array(cmd_to_array),
    .pe_abort(pe_abort), .block_unprotect(block_unprotect), .regs_enable(regs_enable));
  lpc_host_model host (.sys_clk(sys_clk), .lad_out(lad_out), .lad_oe_n(lad_oe_n),
    .lframe_n(lframe_n), .lad_in(lad_in));
  // ====
  // Counts command and abort pulses, keeps the last command
  always @(posedge sys_clk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      got_addr = cmd_addr;
      got_data = cmd_data;
      got_arr = cmd_to_array;
    end
    if (pe_abort === 1'b1) n_abort++;
  end
  // ====
  // Compare helpers and run end
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_val(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Reset with the interface strap set to mode
  task automatic do_reset(input logic mode);
    sys_rst <= 1'b1;
    mux_mode_pin <= mode;
    tick(12);
    sys_rst <= 1'b0;
    tick(2);
    #1;
  endtask
  // ====
  // Link scenarios
  task automatic t_link_write(input logic [31:0] a, input logic [7:0] d, input logic [3:0] ct);
    logic [3:0] lvl [14:17] = '{4'hF, 4'h0, 4'hF, 4'hF};
    int n0 = n_cmd;
    host.write_cycle(a, d, ct, 0);
    chk_bit("early drive", 1'b1, host.oe_seen[13]);
    for (int c = 14; c <= 17; c++) begin
      chk_val("lad level", lvl[c], host.seen[c]);
      chk_bit("lad drive", c == 17, host.oe_seen[c]);
    end
    chk_val("cmd count", n0 + 1, n_cmd);
    chk_val("cmd addr", a, got_addr);
    chk_val("cmd data", d, got_data);
    chk_bit("cmd target", a[ARRAY_SEL_BIT], got_arr);
    $display("test link write done");
  endtask
  task automatic t_link_refused(input logic [3:0] ct, input int abort_at);
    logic idle = 1'b1;
    int n0 = n_cmd;
    host.write_cycle(32'hFFC0_0010, 8'h70, ct, abort_at);
    for (int c = 1; c <= 17; c++) idle &= host.oe_seen[c];
    chk_bit("no drive", 1'b1, idle);
    chk_val("no cmd", n0, n_cmd);
    $display("test link refused done");
  endtask
  task automatic t_late_abort;
    int n0 = n_cmd;
    host.write_cycle(32'hFFC0_0020, 8'hFF, 4'h6, 14);
    chk_bit("abort release", 1'b1, host.oe_seen[15]);
    chk_val("cmd kept", n0 + 1, n_cmd);
    $display("test late abort done");
  endtask
  // ====
  // Multiplexed port scenarios
  task automatic set_addr(input logic [21:0] a);
    tick(1);
    muxed_addr_in <= a[10:0];
    tick(1);
    row_col_select <= 1'b0;
    tick(2);
    muxed_addr_in <= a[21:11];
    tick(1);
    row_col_select <= 1'b1;
    tick(2);
  endtask
  task automatic t_port_write(input logic [21:0] a, input logic [7:0] d);
    int n0 = n_cmd;
    set_addr(a);
    data_io_in <= d;
    write_strobe_n <= 1'b0;
    tick(2);
    write_strobe_n <= 1'b1;
    tick(5);
    chk_val("port cmd count", n0 + 1, n_cmd);
    chk_val("port cmd data", d, got_data);
    chk_val("port cmd addr", {10'h000, a}, got_addr);
    chk_val("latched addr", a, mux_rd_addr);
    chk_bit("port target", 1'b1, got_arr);
    $display("test port write done");
  endtask
  task automatic t_port_read(input logic [21:0] a, input read_mode_type m,
                             input logic [7:0] exp);
    set_addr(a);
    read_mode <= m;
    out_enable_n <= 1'b0;
    tick(3);
    #1;
    chk_bit("read drive", 1'b0, data_io_oe_n);
    chk_val("read data", exp, data_io_out);
    tick(1);
    out_enable_n <= 1'b1;
    tick(2);
    #1;
    chk_bit("output off", 1'b1, data_io_oe_n);
    $display("test port read done");
  endtask
  task automatic t_reset_pin;
    int n0 = n_abort;
    tick(1);
    out_enable_n <= 1'b0;
    pe_busy <= 1'b1;
    tick(3);
    interface_reset_n <= 1'b0;
    tick(4);
    #1;
    chk_bit("reset float", 1'b1, data_io_oe_n);
    chk_val("abort pulses", n0 + 1, n_abort);
    tick(1);
    interface_reset_n <= 1'b1;
    pe_busy <= 1'b0;
    out_enable_n <= 1'b1;
    tick(2);
    $display("test reset pin done");
  endtask
  // ====
  // Main sequence
  initial begin
    do_reset(1'b0);
    chk_bit("link unprotect", 1'b0, block_unprotect);
    chk_bit("link regs", 1'b1, regs_enable);
    t_link_write(32'hFFC0_1234, 8'h3C, 4'h6);
    t_link_write(32'hFF80_5678, 8'hA5, 4'h7);
    t_link_refused(4'h4, 0);
    t_link_refused(4'h6, 5);
    t_late_abort();
    tick(1);
    do_reset(1'b1);
    chk_bit("port unprotect", 1'b1, block_unprotect);
    chk_bit("port regs", 1'b0, regs_enable);
    t_link_refused(4'h6, 0);
    t_port_write(22'h15_A5C3, 8'h40);
    t_port_read(22'h00_0100, RD_ARRAY, array_rdata);
    t_port_read(22'h00_0100, RD_STATUS, status_rdata);
    t_port_read(22'h00_0000, RD_SIGNATURE, EXP_MAKER);
    t_port_read(22'h00_0001, RD_SIGNATURE, EXP_PART);
    t_port_read(22'h00_0002, RD_SIGNATURE, BYTE_ZERO);
    t_reset_pin();
    wrap_up();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200us;
    miscompares++;
    wrap_up();
  end
endmodule
